/* File: otpg_top.v */
// Purpose: Output test pattern generator replacing converter samples toward the link.
// Assumes: Samples arrive on the aclk domain; registers are reached over AXI4-Lite.
// Notes: One generated word is produced per sample accepted into the output buffer.
//
// What this block does
// - Sequencing bit acts only while the mode field selects user patterns.
// - Each user pattern comes from its own low and high byte register pair.
// - Sequencing bit clear: patterns one to four repeat forever, one word each.
// - Sequencing bit set: patterns one to four once, then all-zero words.
// - Long PN reset bit: zero runs the long generator, one holds it reset.
// - Four-bit mode field selects normal, fixed, checkerboard, PN, toggle or user.
// - Short PN reset bit: zero runs the short generator, one holds it reset.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`include "otpg_defs.vh"
module otpg_top #(
  parameter ADDR_W     = 16,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // Clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // Converter samples in
  input  wire [15:0]       sample_data,
  input  wire              sample_valid,
  output wire              sample_ready,
  // Words out toward the link
  output wire [15:0]       out_data,
  output wire              out_valid,
  input  wire              out_ready
);
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  ubyte_ff [0:7];
  reg         aw_hold_ff;
  reg         w_hold_ff;
  reg  [13:0] aw_idx_ff;
  reg  [7:0]  wdata_ff;
  reg         wlane_ff;
  reg         awready_ff;
  reg         wready_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         arready_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [1:0]  slot_ff;
  reg         done_ff;
  reg         phase_ff;
  reg  [22:0] pnl_ff;
  reg  [8:0]  pns_ff;
  reg         nxt_aw_hold;
  reg         nxt_w_hold;
  reg         nxt_bvalid;
  reg  [15:0] gen_word;
  reg  [31:0] rd_word;
  wire        do_write;
  wire [3:0]  wr_sel;
  wire [3:0]  rd_sel;
  wire [3:0]  wr_slot;
  wire [3:0]  mode;
  wire        user_mode;
  wire        accept;
  wire        fifo_ready;
  wire        ctrl_write;
  wire [22:0] pnl_next;
  wire [22:0] pns_next;
  integer     i;

  function [3:0] reg_sel;
    input [13:0] idx;
    begin
      if (idx == `OTPG_CTRL_IDX) begin
        reg_sel = `OTPG_SEL_CTRL;
      end else if (idx >= `OTPG_UP_IDX_FIRST && idx <= `OTPG_UP_IDX_LAST) begin
        reg_sel = idx[3:0];
      end else if (idx == `OTPG_STAT_IDX) begin
        reg_sel = `OTPG_SEL_STAT;
      end else begin
        reg_sel = `OTPG_SEL_NONE;
      end
    end
  endfunction

  function [22:0] lfsr_step;
    input [22:0] s;
    input [4:0]  tap_a;
    input [4:0]  tap_b;
    begin
      lfsr_step = {s[21:0], s[tap_a] ^ s[tap_b]};
    end
  endfunction

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign sample_ready  = fifo_ready;

  // A write commits one cycle after both address and data have been taken.
  assign do_write   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign wr_sel     = reg_sel(aw_idx_ff);
  assign rd_sel     = reg_sel(s_axi_araddr[15:2]);
  assign wr_slot    = wr_sel - `OTPG_SEL_UP_FIRST;
  assign ctrl_write = do_write & wlane_ff & (wr_sel == `OTPG_SEL_CTRL);
  assign mode       = ctrl_ff[`OTPG_F_MODE_HI:`OTPG_F_MODE_LO];
  assign user_mode  = (mode == `OTPG_MODE_USER);
  assign accept     = sample_valid & fifo_ready;
  assign pnl_next   = lfsr_step(pnl_ff, `OTPG_PNL_TAP_A, `OTPG_PNL_TAP_B);
  assign pns_next   = lfsr_step({14'h0000, pns_ff}, `OTPG_PNS_TAP_A, `OTPG_PNS_TAP_B);

  always @* begin
    nxt_aw_hold = aw_hold_ff;
    nxt_w_hold  = w_hold_ff;
    nxt_bvalid  = bvalid_ff;
    if (do_write) begin
      nxt_aw_hold = 1'b0;
      nxt_w_hold  = 1'b0;
      nxt_bvalid  = 1'b1;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_hold = 1'b1;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_hold = 1'b1;
    end
  end

  always @* begin
    rd_word = 32'h00000000;
    if (rd_sel == `OTPG_SEL_CTRL) begin
      rd_word[7:0] = ctrl_ff & `OTPG_CTRL_WMASK;
    end else if (rd_sel >= `OTPG_SEL_UP_FIRST && rd_sel <= `OTPG_SEL_UP_LAST) begin
      rd_word[7:0] = ubyte_ff[rd_sel[2:0] - 3'h1];
    end else if (rd_sel == `OTPG_SEL_STAT) begin
      rd_word[7:0] = {mode, out_valid, done_ff, slot_ff};
    end
  end

  // Word selection for the active test mode.
  always @* begin
    gen_word = sample_data;
    case (mode)
      `OTPG_MODE_NORMAL:   gen_word = sample_data;
      `OTPG_MODE_MIDSCALE: gen_word = `OTPG_WORD_MID;
      `OTPG_MODE_POSFS:    gen_word = `OTPG_WORD_POSFS;
      `OTPG_MODE_NEGFS:    gen_word = `OTPG_WORD_NEGFS;
      `OTPG_MODE_CHECK:    gen_word = phase_ff ? `OTPG_WORD_CHECK_B : `OTPG_WORD_CHECK_A;
      `OTPG_MODE_PNLONG:   gen_word = pnl_ff[15:0];
      `OTPG_MODE_PNSHORT:  gen_word = {pns_ff[6:0], pns_ff};
      `OTPG_MODE_TOGGLE:   gen_word = phase_ff ? `OTPG_WORD_TOG_B : `OTPG_WORD_TOG_A;
      `OTPG_MODE_USER: begin
        if (done_ff) begin
          gen_word = `OTPG_WORD_ZERO;
        end else begin
          gen_word = {ubyte_ff[{slot_ff, 1'b1}], ubyte_ff[{slot_ff, 1'b0}]};
        end
      end
      default:             gen_word = sample_data;
    endcase
  end

  // Register bus slave.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_idx_ff  <= 14'h0000;
      wdata_ff   <= `OTPG_BYTE_RST;
      wlane_ff   <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `OTPG_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `OTPG_RESP_OKAY;
      rdata_ff   <= 32'h00000000;
      ctrl_ff    <= `OTPG_CTRL_RST;
      for (i = 0; i < 8; i = i + 1) begin
        ubyte_ff[i] <= `OTPG_BYTE_RST;
      end
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      bvalid_ff  <= nxt_bvalid;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
      if (s_axi_awvalid && awready_ff) begin
        aw_idx_ff <= s_axi_awaddr[15:2];
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff <= s_axi_wdata[7:0];
        wlane_ff <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_ff <= (wr_sel == `OTPG_SEL_NONE) ? `OTPG_RESP_SLVERR : `OTPG_RESP_OKAY;
        if (ctrl_write) begin
          ctrl_ff <= wdata_ff & `OTPG_CTRL_WMASK;
        end
        if (wlane_ff && wr_sel >= `OTPG_SEL_UP_FIRST && wr_sel <= `OTPG_SEL_UP_LAST) begin
          ubyte_ff[wr_slot[2:0]] <= wdata_ff;
        end
      end
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_word;
        rresp_ff   <= (rd_sel == `OTPG_SEL_NONE) ? `OTPG_RESP_SLVERR : `OTPG_RESP_OKAY;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end else if (!rvalid_ff) begin
        arready_ff <= 1'b1;
      end
    end
  end

  // Pattern sequencing; any control write or leaving user mode restarts it.
  always @(posedge aclk) begin
    if (!aresetn) begin
      slot_ff  <= `OTPG_SLOT_FIRST;
      done_ff  <= 1'b0;
      phase_ff <= 1'b0;
    end else if (ctrl_write || !user_mode) begin
      slot_ff  <= `OTPG_SLOT_FIRST;
      done_ff  <= 1'b0;
      phase_ff <= ctrl_write ? 1'b0 : (phase_ff ^ accept);
    end else if (accept && !done_ff) begin
      slot_ff <= slot_ff + 2'h1;
      if (slot_ff == `OTPG_SLOT_LAST && ctrl_ff[`OTPG_F_USRSEQ]) begin
        done_ff <= 1'b1;
      end
    end
  end

  // Pseudorandom generators; a set reset bit holds the seed.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pnl_ff <= `OTPG_PNL_SEED;
      pns_ff <= `OTPG_PNS_SEED;
    end else begin
      if (ctrl_ff[`OTPG_F_PNL_RST]) begin
        pnl_ff <= `OTPG_PNL_SEED;
      end else if (accept && mode == `OTPG_MODE_PNLONG) begin
        pnl_ff <= pnl_next;
      end
      if (ctrl_ff[`OTPG_F_PNS_RST]) begin
        pns_ff <= `OTPG_PNS_SEED;
      end else if (accept && mode == `OTPG_MODE_PNSHORT) begin
        pns_ff <= pns_next[8:0];
      end
    end
  end

  otpg_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (sample_valid),
    .in_ready  (fifo_ready),
    .in_data   (gen_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule

/* File: otpg_defs.vh */
// Purpose: Shared constants of the output test pattern generator.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Definitions only.
`ifndef OTPG_DEFS_VH
`define OTPG_DEFS_VH

`define OTPG_CTRL_IDX      14'h0550
`define OTPG_UP_IDX_FIRST  14'h0551
`define OTPG_UP_IDX_LAST   14'h0558
`define OTPG_STAT_IDX      14'h0560

`define OTPG_SEL_CTRL      4'h0
`define OTPG_SEL_UP_FIRST  4'h1
`define OTPG_SEL_UP_LAST   4'h8
`define OTPG_SEL_STAT      4'h9
`define OTPG_SEL_NONE      4'hF

`define OTPG_F_USRSEQ      7
`define OTPG_F_PNL_RST     5
`define OTPG_F_PNS_RST     4
`define OTPG_F_MODE_HI     3
`define OTPG_F_MODE_LO     0
`define OTPG_CTRL_WMASK    8'hBF
`define OTPG_CTRL_RST      8'h00
`define OTPG_BYTE_RST      8'h00

`define OTPG_MODE_NORMAL   4'h0
`define OTPG_MODE_MIDSCALE 4'h1
`define OTPG_MODE_POSFS    4'h2
`define OTPG_MODE_NEGFS    4'h3
`define OTPG_MODE_CHECK    4'h4
`define OTPG_MODE_PNLONG   4'h5
`define OTPG_MODE_PNSHORT  4'h6
`define OTPG_MODE_TOGGLE   4'h7
`define OTPG_MODE_USER     4'h8

`define OTPG_WORD_ZERO     16'h0000
`define OTPG_WORD_MID      16'h0000
`define OTPG_WORD_POSFS    16'h7FFF
`define OTPG_WORD_NEGFS    16'h8000
`define OTPG_WORD_CHECK_A  16'hAAAA
`define OTPG_WORD_CHECK_B  16'h5555
`define OTPG_WORD_TOG_A    16'h0000
`define OTPG_WORD_TOG_B    16'hFFFF

`define OTPG_PNL_SEED      23'h7FFFFF
`define OTPG_PNS_SEED      9'h1FF
`define OTPG_PNL_TAP_A     5'h16
`define OTPG_PNL_TAP_B     5'h11
`define OTPG_PNS_TAP_A     5'h08
`define OTPG_PNS_TAP_B     5'h04

`define OTPG_SLOT_FIRST    2'h0
`define OTPG_SLOT_LAST     2'h3
`define OTPG_RESP_OKAY     2'h0
`define OTPG_RESP_SLVERR   2'h2

`endif

/* File: otpg_fifo.v */
// Purpose: Small first-in first-out buffer with valid and ready on both sides.
// Assumes: DEPTH is a power of two and equals 2**AW.
// Notes: Read data and all flags come from registers.
`timescale 1ns/1ps
module otpg_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL_CNT = DEPTH;
  localparam [AW:0] ONE_CNT  = 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  reg [AW:0]      nxt_count;
  reg             in_ready_ff;
  reg             out_valid_ff;
  reg [WIDTH-1:0] out_data_ff;
  wire            push;
  wire            pop;

  assign push      = in_valid & in_ready_ff;
  assign pop       = (count_ff != {(AW+1){1'b0}}) & (~out_valid_ff | out_ready);
  assign in_ready  = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;

  always @* begin
    nxt_count = count_ff;
    case ({push, pop})
      2'b10:   nxt_count = count_ff + ONE_CNT;
      2'b01:   nxt_count = count_ff - ONE_CNT;
      default: nxt_count = count_ff;
    endcase
  end

  always @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_ff    <= {AW{1'b0}};
      rd_ptr_ff    <= {AW{1'b0}};
      count_ff     <= {(AW+1){1'b0}};
      in_ready_ff  <= 1'b0;
      out_valid_ff <= 1'b0;
      out_data_ff  <= {WIDTH{1'b0}};
    end else begin
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != FULL_CNT);
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff    <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
        out_data_ff  <= mem[rd_ptr_ff];
        out_valid_ff <= 1'b1;
      end else if (out_ready) begin
        out_valid_ff <= 1'b0;
      end
    end
  end
endmodule

/* File: otpg_link_sink.sv */
// Purpose: Receiver model that captures generated words from the output stream.
// Assumes: Same clock as the generator; words move on out_valid and out_ready both high.
// Notes: stall holds ready low; slow drops ready on every other cycle.
`timescale 1ns/1ps
module otpg_link_sink (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Pacing from the bench
  input  wire logic        stall,
  input  wire logic        slow,
  // Stream in
  input  wire logic [15:0] out_data,
  input  wire logic        out_valid,
  output logic             out_ready
);
  logic [15:0] got[$];
  logic        ph_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_ready <= 1'b0;
      ph_ff     <= 1'b0;
    end else begin
      if (out_valid && out_ready)
        got.push_back(out_data);
      ph_ff     <= ~ph_ff;
      out_ready <= !stall && !(slow && ph_ff);
    end
  end
endmodule

/* File: otpg_top_properties.sv */
// Purpose: Port-level assertions for the test pattern generator.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes: Bound to otpg_top below.
`timescale 1ns/1ps
module otpg_chk (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Streams
  input wire logic        sample_valid,
  input wire logic        sample_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [15:0] out_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_o_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  property p_aw_lock; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]; endproperty
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_err; s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0; endproperty
  property p_o_lat; sample_valid && sample_ready && !out_valid |-> ##[1:3] out_valid;
  endproperty

  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  a_o_hold: assert property (p_o_hold) else $error("output word not held");
  a_aw_lock: assert property (p_aw_lock) else $error("second write taken early");
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  a_err: assert property (p_err) else $error("error read not zero");
  a_o_lat: assert property (p_o_lat) else $error("generated word late");

  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_full: cover property (!sample_ready && out_valid && !out_ready);
endmodule

bind otpg_top otpg_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_rresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sample_valid, .sample_ready,
  .out_valid, .out_ready, .out_data);

/* File: tb_top.sv */
// Purpose: Register and stream tests of the output test pattern generator.
// Assumes: Byte address is four times the register index.
// Notes: Samples count up so pass-through words are predictable.
`timescale 1ns/1ps
`include "otpg_defs.vh"
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, sample_data = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sample_valid = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         sample_ready, out_valid, out_ready;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  out_data;
  int          num_errors = 0, check_count = 0, left = 0;
  logic [15:0] eq[$];
  logic [7:0]  ub[1:8];
  logic [3:0]  fm[5] = '{`OTPG_MODE_MIDSCALE, `OTPG_MODE_POSFS, `OTPG_MODE_NEGFS,
                         `OTPG_MODE_CHECK, `OTPG_MODE_TOGGLE};
  logic [15:0] fa[5] = '{`OTPG_WORD_MID, `OTPG_WORD_POSFS, `OTPG_WORD_NEGFS,
                         `OTPG_WORD_CHECK_A, `OTPG_WORD_TOG_A};
  logic [15:0] fb[5] = '{`OTPG_WORD_MID, `OTPG_WORD_POSFS, `OTPG_WORD_NEGFS,
                         `OTPG_WORD_CHECK_B, `OTPG_WORD_TOG_B};

  always #5 aclk = ~aclk;

  otpg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .sample_data, .sample_valid, .sample_ready, .out_data, .out_valid,
    .out_ready);
  otpg_link_sink sink (.aclk, .aresetn, .stall, .slow, .out_data, .out_valid, .out_ready);

  // Sample source: sends left samples, each one larger than the last.
  always @(posedge aclk) begin
    if (sample_valid && sample_ready) begin
      left = left - 1;
      sample_data <= sample_data + 16'h1;
    end
    sample_valid <= (left > 0);
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && t < 200);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    chk(t < 200, 1'b1);
  endtask

  task rc(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && t < 200);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    chk(t < 200, 1'b1);
  endtask

  // Sends n samples and compares the captured words with eq when it is filled.
  task run(input int n);
    int t;
    @(posedge aclk);
    sink.got.delete();
    left = n;
    t = 0;
    while (sink.got.size() < n && t < 500) begin
      @(posedge aclk);
      t++;
    end
    chk(sink.got.size(), n);
    foreach (eq[i]) if (i < sink.got.size()) chk(sink.got[i], eq[i]);
    eq.delete();
  endtask

  task pat(input int n);
    eq.push_back({ub[2*n], ub[2*n-1]});
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    test_done;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rc(16'h1540, 32'h0, `OTPG_RESP_OKAY);
    for (int i = 1; i <= 8; i++) begin
      ub[i] = 8'(i * 37 + 5);
      rc(16'h1540 + 16'(4 * i), 32'h0, `OTPG_RESP_OKAY);
      wr(16'h1540 + 16'(4 * i), ub[i], `OTPG_RESP_OKAY);
      rc(16'h1540 + 16'(4 * i), {24'h0, ub[i]}, `OTPG_RESP_OKAY);
    end
    $display("test registers done");
    wr(16'h1540, 8'h08, `OTPG_RESP_OKAY);
    slow <= 1'b1;
    for (int k = 0; k < 10; k++) pat(k % 4 + 1);
    run(10);
    slow <= 1'b0;
    wr(16'h1540, 8'h88, `OTPG_RESP_OKAY);
    for (int k = 1; k <= 4; k++) pat(k);
    eq.push_back(`OTPG_WORD_ZERO);
    eq.push_back(`OTPG_WORD_ZERO);
    run(6);
    // Status after a single pass: user mode, done set, slot wrapped, output idle.
    rc(16'h1580, 32'h00000084, `OTPG_RESP_OKAY);
    wr(16'h1540, 8'h80, `OTPG_RESP_OKAY);
    for (int k = 0; k < 3; k++) eq.push_back(sample_data + 16'(k));
    run(3);
    $display("test user patterns done");
    for (int j = 0; j < 5; j++) begin
      wr(16'h1540, {4'h0, fm[j]}, `OTPG_RESP_OKAY);
      eq.push_back(fa[j]);
      eq.push_back(fb[j]);
      eq.push_back(fa[j]);
      run(3);
    end
    $display("test fixed modes done");
    // Both generators load all ones while held, so every held word is 0xFFFF.
    for (int j = 0; j < 2; j++) begin
      wr(16'h1540, j ? 8'h16 : 8'h25, `OTPG_RESP_OKAY);
      for (int k = 0; k < 3; k++) eq.push_back(16'hFFFF);
      run(3);
      wr(16'h1540, j ? 8'h06 : 8'h05, `OTPG_RESP_OKAY);
      run(4);
      chk(sink.got[3] !== 16'hFFFF, 1'b1);
    end
    $display("test pn done");
    wr(16'h1600, 8'h55, `OTPG_RESP_SLVERR);
    rc(16'h1600, 32'h0, `OTPG_RESP_SLVERR);
    wr(16'h1540, 8'hFF, `OTPG_RESP_OKAY);
    rc(16'h1540, 32'hBF, `OTPG_RESP_OKAY);
    // A write with the low byte lane disabled must leave the pattern byte alone.
    s_axi_wstrb <= 4'h0;
    wr(16'h1544, 8'h11, `OTPG_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rc(16'h1544, {24'h0, ub[1]}, `OTPG_RESP_OKAY);
    $display("test access done");
    stall <= 1'b1;
    for (int k = 0; k < 12; k++) eq.push_back(sample_data + 16'(k));
    fork
      run(12);
      begin
        repeat (40) @(posedge aclk);
        chk(left, 3);
        stall <= 1'b0;
      end
    join
    $display("test buffer done");
    test_done;
  end
endmodule
